// File: dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host processor on the register port; it moves only after a clock edge.
module host_model
   import sample_fifo_pkg::*;
(
   // Clock.
   input  wire logic       clk_sys_i,
   // Register port.
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_rd_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_rvalid_i
);

   // Idle port at time zero.
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
   end

   // One-cycle write; the data is scrambled afterwards so no stale value
   // can pass for a held one.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~d;
   endtask

   // One-cycle read; the answer is taken one cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_o   <= 1'b0;
      @(posedge clk_sys_i);
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask

   task automatic sys_wr(input logic [7:0] d);
      wr(ADDR_SYSTEM_CTRL, d | 8'h08);
   endtask

endmodule // host_model

`default_nettype wire

// File: dv/sample_fifo_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// Bench top: feeds samples and context, checks through the host model.
module sample_fifo_control_tb_top;
   import sample_fifo_pkg::*;
   logic       clk_sys_i, reset_n_i, reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sample_data, lost_exp;
   logic       status_read, sample_valid, sample_ready, proximity;
   logic       rate_low, conv_active, afull_flag, ready_flag;
   logic       sensor_pd, power_save;
   int         bad_count, comparisons;

   // 200 MHz clock.
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   sample_fifo_control i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
      .status_read_i(status_read), .sample_valid_i(sample_valid),
      .sample_ready_o(sample_ready), .sample_data_i(sample_data),
      .proximity_mode_i(proximity), .rate_low_i(rate_low),
      .conversion_active_i(conv_active), .almost_full_flag_o(afull_flag),
      .sample_ready_flag_o(ready_flag), .sensor_power_down_o(sensor_pd),
      .power_save_o(power_save));

   host_model i_host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr),
      .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd),
      .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

   /////////////////////////////////////////////////////////////////////////
   // Byte compare; a missing read answer arrives here as unknowns.
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // Register read compare.
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      i_host.rd(a, d, v);
      chk($sformatf("reg %h", a), e, (v === 1'b1) ? d : 8'hXX);
   endtask

   // Flag compare.
   task automatic fchk(input string n, input logic e, input logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask

   // Offers n samples, then lets the ingress buffer drain.
   task automatic push(input int n, input logic [7:0] base);
      @(posedge clk_sys_i);
      sample_valid <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         sample_data <= base + 8'(i);
         @(posedge clk_sys_i);
         while (sample_ready !== 1'b1)
            @(posedge clk_sys_i);
      end
      sample_valid <= 1'b0;
      repeat (24) @(posedge clk_sys_i);
   endtask

   // Status register read as seen by this block.
   task automatic stat_pulse();
      @(posedge clk_sys_i);
      status_read <= 1'b1;
      @(posedge clk_sys_i);
      status_read <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   // Empty the store, then set the behaviour bits.
   task automatic flush_cfg(input logic [7:0] cfg);
      i_host.wr(ADDR_BEHAVIOUR, 8'h10);
      i_host.wr(ADDR_BEHAVIOUR, cfg);
   endtask

   task automatic t_reset();
      @(posedge clk_sys_i);
      fchk("ingress ready", 1'b1, sample_ready);
      rchk(ADDR_AFULL_THRESH, 8'h3F);
      rchk(ADDR_BEHAVIOUR, 8'h00);
      rchk(ADDR_SYSTEM_CTRL, 8'h00);
      rchk(ADDR_LOST_COUNT, 8'h00);
      rchk(ADDR_FILL_COUNT, 8'h00);
      i_host.wr(ADDR_WRITE_INDEX, 8'h11);
      rchk(ADDR_WRITE_INDEX, 8'h00);
      rchk(8'h20, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_order();
      push(3, 8'hA0);
      rchk(ADDR_FILL_COUNT, 8'h03);
      rchk(ADDR_WRITE_INDEX, 8'h03);
      rchk(ADDR_READ_PORT, 8'hA0);
      i_host.wr(ADDR_READ_PORT, 8'h55);
      rchk(ADDR_READ_PORT, 8'hA1);
      i_host.wr(ADDR_READ_INDEX, 8'h00);
      rchk(ADDR_READ_PORT, 8'hA0);
      rchk(ADDR_FILL_COUNT, 8'h00);
      rchk(ADDR_READ_PORT, 8'h00);
      rchk(ADDR_READ_INDEX, 8'h01);
      $display("test order done");
   endtask

   // Overfill by two; stop mode keeps the oldest, the others overwrite.
   task automatic t_full(input logic roll, input logic proximity_mode);
      logic [7:0] wi;
      wi = (roll | proximity_mode) ? 8'h02 : 8'h00;
      flush_cfg({6'h00, roll, 1'b0});
      proximity <= proximity_mode;
      push(130, 8'h00);
      lost_exp = lost_exp + 8'h02;
      rchk(ADDR_FILL_COUNT, 8'h80);
      rchk(ADDR_LOST_COUNT, lost_exp);
      rchk(ADDR_WRITE_INDEX, wi);
      rchk(ADDR_READ_INDEX, wi);
      rchk(ADDR_READ_PORT, wi);
      proximity <= 1'b0;
      $display("test full done");
   endtask

   // Threshold zero with roll-over keeps the almost-full condition alive.
   task automatic t_flags(input logic once);
      flush_cfg({5'h00, once, 2'b10});
      i_host.wr(ADDR_AFULL_THRESH, 8'h00);
      // Earlier tests leave sticky flags set; start from a clean status.
      stat_pulse();
      push(127, 8'h00);
      fchk("almost full", 1'b0, afull_flag);
      push(1, 8'h7F);
      fchk("almost full", 1'b1, afull_flag);
      stat_pulse();
      fchk("almost full", 1'b0, afull_flag);
      fchk("sample ready", 1'b0, ready_flag);
      push(1, 8'h80);
      lost_exp = lost_exp + 8'h01;
      fchk("almost full", ~once, afull_flag);
      rchk(ADDR_READ_PORT, 8'h01);
      fchk("sample ready", 1'b1, ready_flag);
      i_host.wr(ADDR_BEHAVIOUR, 8'h0A);
      rchk(ADDR_READ_PORT, 8'h02);
      fchk("sample ready", 1'b0, ready_flag);
      rchk(ADDR_LOST_COUNT, lost_exp);
      $display("test flags done");
   endtask

   task automatic t_power();
      flush_cfg(8'h00);
      push(255, 8'h00);
      rchk(ADDR_LOST_COUNT, 8'h7F);
      flush_cfg(8'h00);
      stat_pulse();
      push(1, 8'h10);
      fchk("sample ready", 1'b1, ready_flag);
      i_host.sys_wr(8'h02);
      repeat (2) @(posedge clk_sys_i);
      fchk("power save", 1'b1, power_save);
      fchk("sample ready", 1'b0, ready_flag);
      rchk(ADDR_SYSTEM_CTRL, 8'h0A);
      i_host.wr(ADDR_AFULL_THRESH, 8'h21);
      rchk(ADDR_AFULL_THRESH, 8'h21);
      i_host.sys_wr(8'h04);
      rate_low <= 1'b1;
      @(posedge clk_sys_i);
      fchk("sensor off", 1'b1, sensor_pd);
      conv_active <= 1'b1;
      @(posedge clk_sys_i);
      fchk("sensor off", 1'b0, sensor_pd);
      conv_active <= 1'b0;
      rate_low <= 1'b0;
      @(posedge clk_sys_i);
      fchk("sensor off", 1'b0, sensor_pd);
      i_host.sys_wr(8'h01);
      repeat (2) @(posedge clk_sys_i);
      rchk(ADDR_AFULL_THRESH, 8'h3F);
      rchk(ADDR_SYSTEM_CTRL, 8'h00);
      rchk(ADDR_FILL_COUNT, 8'h00);
      $display("test power done");
   endtask

   // Counts, verdict and the end of the run.
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence; the lost counter is never flushed, so it is tracked.
   initial
   begin
      reset_n_i    = 1'b0;
      status_read  = 1'b0;
      sample_valid = 1'b0;
      sample_data  = 8'h00;
      proximity    = 1'b0;
      rate_low     = 1'b0;
      conv_active  = 1'b0;
      lost_exp     = 8'h00;
      bad_count    = 0;
      comparisons  = 0;
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_order();
      t_full(1'b0, 1'b0);
      t_full(1'b1, 1'b0);
      t_full(1'b0, 1'b1);
      t_flags(1'b0);
      t_flags(1'b1);
      t_power();
      end_of_test();
   end

   // Watchdog, far beyond the roughly 1400 cycles the run needs.
   initial
   begin
      #200us;
      bad_count++;
      $display("[FAIL] watchdog expected finish seen hang");
      end_of_test();
   end

endmodule // sample_fifo_control_tb_top

`default_nettype wire

// File: logic/sample_fifo_control.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Small ingress buffer between the sample source and the sample store.
module ingress_buffer
   import sample_fifo_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock and reset.
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   // Filling side.
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic             do_in;
   logic             do_out;

   // Full and empty come straight from the occupancy count.
   assign in_ready_o  = (count != (PW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign do_in       = in_valid_i & in_ready_o;
   assign do_out      = out_valid_o & out_ready_i;

   // Storage has no reset; only the pointers matter.
   always_ff @(posedge clk_sys_i)
   begin
      if (do_in)
         mem[wr_ptr] <= in_data_i;
   end

   // Pointers and count.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (do_in)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_out)
            rd_ptr <= rd_ptr + 1'b1;
         count <= count + (PW+1)'(do_in) - (PW+1)'(do_out);
      end
   end
endmodule // ingress_buffer

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Each lost sample bumps the 7-bit lost counter, saturating at 0x7F.
// - Fill level counts up per item stored into a free slot, down per host read-out.
// - Reading the read port returns and pops the next item; writes ignored.
// - Almost-full when free space equals threshold; threshold resets to 0x3F.
// - Flush empties the store, zeroes both indices and fill; self-clears.
// - Flags clear on status read; also on read-port read if enabled.
// - Repeat mode re-sets almost-full on every stored sample while condition holds.
// - Once mode sets almost-full only on a fresh almost-full detection.
// - Roll-over mode: push into full store overwrites oldest, both indices move.
// - Stop mode: push into full store is dropped, write index holds.
// - In proximity mode pushes always go in, whatever roll-over says.
// - One-channel bit is stored and read back but steers nothing.
// - Dynamic power-down powers sensor off between samples at low rates only.
// - Power save keeps registers working but holds all flags at zero.
// - Write index advances by one, wrapping, for each stored sample.
// - Host may rewrite the read index; popping resumes from there.
// - Soft reset returns every register to reset values, then self-clears.
module sample_fifo_control
   import sample_fifo_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk_sys_i,
   input  wire logic                reset_n_i,
   // Host register port.
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic [7:0]          reg_wdata_i,
   input  wire logic                reg_rd_i,
   output logic      [7:0]          reg_rdata_o,
   output logic                     reg_rvalid_o,
   input  wire logic                status_read_i,
   // Sample source.
   input  wire logic                sample_valid_i,
   output logic                     sample_ready_o,
   input  wire logic [SAMPLE_W-1:0] sample_data_i,
   // Acquisition context.
   input  wire logic                proximity_mode_i,
   input  wire logic                rate_low_i,
   input  wire logic                conversion_active_i,
   // Status and power outputs.
   output logic                     almost_full_flag_o,
   output logic                     sample_ready_flag_o,
   output logic                     sensor_power_down_o,
   output logic                     power_save_o
);
   logic [SAMPLE_W-1:0] store [STORE_DEPTH];
   logic [6:0]          write_index;
   logic [6:0]          read_index;
   logic [7:0]          fill_level;
   logic [6:0]          lost_sample_count;
   logic [6:0]          almost_full_space;
   logic                flush_request;
   logic                read_clears_flags;
   logic                almost_full_repeat_select;
   logic                roll_over_on_full;
   logic                one_channel_select;
   logic                dynamic_power_down;
   logic                power_save;
   logic                soft_reset;
   logic                afull_cond_q;
   logic                core_rst_n;
   logic                ing_valid;
   logic                ing_take;
   logic [SAMPLE_W-1:0] ing_data;
   logic                port_read;
   logic                pop;
   logic                full;
   logic                push_store;
   logic                push_drop;
   logic                host_rd_index_wr;
   logic [7:0]          next_fill;
   logic                next_afull_cond;
   logic                afull_set;
   logic                flag_clear;

   // Address match shared by the read and write paths.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Soft reset acts as one cycle of reset on the whole block except the register read path.

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         soft_reset <= 1'b0;
      else
         soft_reset <= reg_wr_i & hit(reg_addr_i, ADDR_SYSTEM_CTRL)
                       & reg_wdata_i[BIT_SOFT_RESET];
   end

   assign core_rst_n = reset_n_i & ~soft_reset;

   ////////////////////////////////////////////////////////////////////////////
   // Ingress buffer; it is drained only while the store side is running.

   // Draining stops in power save and during a flush, so the source stalls.
   assign ing_take = ~power_save & ~flush_request;

   ingress_buffer #(
      .WIDTH (SAMPLE_W),
      .DEPTH (INGRESS_DEPTH)
   ) u_ingress (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (core_rst_n),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (sample_ready_o),
      .in_data_i   (sample_data_i),
      .out_valid_o (ing_valid),
      .out_ready_i (ing_take),
      .out_data_o  (ing_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Push and pop decisions.

   assign port_read = reg_rd_i & hit(reg_addr_i, ADDR_READ_PORT);
   assign pop       = port_read & (fill_level != 8'h00);
   // A pop in the same cycle frees a slot, so the push is then ordinary.
   assign full      = (fill_level == STORE_FULL) & ~pop;
   assign push_store = ing_valid & ing_take
                       & (~full | roll_over_on_full | proximity_mode_i);
   assign push_drop  = ing_valid & ing_take & full
                       & ~roll_over_on_full & ~proximity_mode_i;
   assign host_rd_index_wr = reg_wr_i & hit(reg_addr_i, ADDR_READ_INDEX);

   // Sample storage; contents need no reset.
   always_ff @(posedge clk_sys_i)
   begin
      if (push_store)
         store[write_index] <= ing_data;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n || flush_request)
         write_index <= RST_INDEX;
      else if (push_store)
         write_index <= write_index + 7'h01;
   end

   // Read index: flush first, then host rewrite, then pop or roll-over.
   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n || flush_request)
         read_index <= RST_INDEX;
      else if (host_rd_index_wr)
         read_index <= reg_wdata_i[6:0];
      else if (pop || (push_store && full))
         read_index <= read_index + 7'h01;
   end

   always_comb
   begin
      next_fill = fill_level;
      if (push_store && !full)
         next_fill = next_fill + 8'h01;
      if (pop)
         next_fill = next_fill - 8'h01;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n || flush_request)
         fill_level <= RST_FILL;
      else
         fill_level <= next_fill;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n)
         lost_sample_count <= RST_LOST;
      else if ((push_drop || (push_store && full))
               && lost_sample_count != LOST_MAX)
         lost_sample_count <= lost_sample_count + 7'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   // Threshold register.
   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n)
         almost_full_space <= RST_AFULL_THRESH;
      else if (reg_wr_i && hit(reg_addr_i, ADDR_AFULL_THRESH))
         almost_full_space <= reg_wdata_i[6:0];
   end

   // Behaviour control; the flush bit stands for one cycle only.
   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n)
      begin
         flush_request             <= 1'b0;
         read_clears_flags         <= 1'b0;
         almost_full_repeat_select <= 1'b0;
         roll_over_on_full         <= 1'b0;
      end
      else if (reg_wr_i && hit(reg_addr_i, ADDR_BEHAVIOUR))
      begin
         flush_request             <= reg_wdata_i[BIT_FLUSH_REQUEST];
         read_clears_flags         <= reg_wdata_i[BIT_READ_CLEARS];
         almost_full_repeat_select <= reg_wdata_i[BIT_AFULL_REPEAT];
         roll_over_on_full         <= reg_wdata_i[BIT_ROLL_OVER];
      end
      else
         flush_request <= 1'b0;
   end

   // System control; the soft reset bit lives in its own flop above.
   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n)
      begin
         one_channel_select <= 1'b0;
         dynamic_power_down <= 1'b0;
         power_save         <= 1'b0;
      end
      else if (reg_wr_i && hit(reg_addr_i, ADDR_SYSTEM_CTRL))
      begin
         one_channel_select <= reg_wdata_i[BIT_ONE_CHANNEL];
         dynamic_power_down <= reg_wdata_i[BIT_DYN_POWER_DOWN];
         power_save         <= reg_wdata_i[BIT_POWER_SAVE];
      end
   end

   assign sensor_power_down_o = power_save
                                | (dynamic_power_down & rate_low_i
                                   & ~conversion_active_i);
   assign power_save_o        = power_save;

   ////////////////////////////////////////////////////////////////////////////
   // Status flags.

   assign next_afull_cond = ((STORE_FULL - next_fill)
                             == {1'b0, almost_full_space});

   assign afull_set = almost_full_repeat_select
                      ? (next_afull_cond & ~afull_cond_q)
                      : (push_store & next_afull_cond);

   assign flag_clear = status_read_i | (port_read & read_clears_flags);

   // Condition history for edge detection in once mode.
   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n)
         afull_cond_q <= 1'b0;
      else
         afull_cond_q <= next_afull_cond;
   end

   // Set wins over clear; power save holds both flags low.
   always_ff @(posedge clk_sys_i)
   begin
      if (!core_rst_n || power_save)
      begin
         almost_full_flag_o  <= 1'b0;
         sample_ready_flag_o <= 1'b0;
      end
      else
      begin
         almost_full_flag_o  <= afull_set
                                | (almost_full_flag_o & ~flag_clear);
         sample_ready_flag_o <= push_store
                                | (sample_ready_flag_o & ~flag_clear);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read path, answered one cycle after the request.

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         reg_rdata_o  <= RST_DATA;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         reg_rdata_o  <= RST_DATA;
         if (reg_rd_i)
         begin
            unique case (reg_addr_i)
               ADDR_WRITE_INDEX:  reg_rdata_o <= {1'b0, write_index};
               ADDR_READ_INDEX:   reg_rdata_o <= {1'b0, read_index};
               ADDR_LOST_COUNT:   reg_rdata_o <= {1'b0, lost_sample_count};
               ADDR_FILL_COUNT:   reg_rdata_o <= fill_level;
               ADDR_READ_PORT:    reg_rdata_o <= pop ? store[read_index]
                                                     : RST_DATA;
               ADDR_AFULL_THRESH: reg_rdata_o <= {1'b0, almost_full_space};
               ADDR_BEHAVIOUR:    reg_rdata_o <= {3'h0, flush_request,
                                     read_clears_flags,
                                     almost_full_repeat_select,
                                     roll_over_on_full, 1'b0};
               ADDR_SYSTEM_CTRL:  reg_rdata_o <= {4'h0, one_channel_select,
                                     dynamic_power_down, power_save,
                                     soft_reset};
               default:           reg_rdata_o <= RST_DATA;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!core_rst_n);

   property p_lost_count;
      (push_drop && lost_sample_count != LOST_MAX)
         |=> lost_sample_count == $past(lost_sample_count) + 7'h01;
   endproperty
   a_lost_count: assert property (p_lost_count)
      else $error("lost counter did not count a dropped sample");

   property p_lost_sat;
      lost_sample_count == LOST_MAX |=> lost_sample_count == LOST_MAX;
   endproperty
   a_lost_sat: assert property (p_lost_sat)
      else $error("lost counter left saturation");

   property p_fill_up;
      (push_store && !full && !pop && !flush_request)
         |=> fill_level == $past(fill_level) + 8'h01;
   endproperty
   a_fill_up: assert property (p_fill_up)
      else $error("fill level did not rise on push");

   property p_pop_index;
      (pop && !host_rd_index_wr && !flush_request)
         |=> read_index == $past(read_index) + 7'h01 && reg_rvalid_o;
   endproperty
   a_pop_index: assert property (p_pop_index)
      else $error("read port pop did not advance read index");

   property p_flush;
      flush_request |=> write_index == 7'h00 && read_index == 7'h00
                        && fill_level == 8'h00 && !flush_request;
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush did not empty the store");

   property p_once;
      (almost_full_repeat_select && status_read_i && !afull_set
       && !power_save) ##1 (!afull_set)[*2] |-> !almost_full_flag_o;
   endproperty
   a_once: assert property (p_once)
      else $error("almost-full flag came back without a new detection");

   property p_roll;
      (push_store && full && !host_rd_index_wr && !flush_request)
         |=> read_index == $past(read_index) + 7'h01
             && write_index == $past(write_index) + 7'h01;
   endproperty
   a_roll: assert property (p_roll)
      else $error("roll-over did not move both indices");

   property p_drop;
      (push_drop && !flush_request)
         |=> write_index == $past(write_index)
             && fill_level == STORE_FULL;
   endproperty
   a_drop: assert property (p_drop)
      else $error("dropped sample moved the write index");

   property p_power_save;
      power_save |=> !almost_full_flag_o && !sample_ready_flag_o;
   endproperty
   a_power_save: assert property (p_power_save)
      else $error("flag set during power save");

   property p_empty_read;
      (port_read && fill_level == 8'h00 && !host_rd_index_wr
       && !push_store) |=> read_index == $past(read_index)
                           && fill_level == 8'h00;
   endproperty
   a_empty_read: assert property (p_empty_read)
      else $error("empty read disturbed the store");

   c_roll: cover property (push_store && full);
   c_drop: cover property (push_drop);
   c_afull: cover property ($rose(almost_full_flag_o));
   c_flush: cover property (flush_request && fill_level != 8'h00);

endmodule // sample_fifo_control

`default_nettype wire

// File: logic/sample_fifo_pkg.sv
`default_nettype none

package sample_fifo_pkg;

   // Register offsets on the host register port.
   localparam logic [7:0] ADDR_WRITE_INDEX   = 8'h04;
   localparam logic [7:0] ADDR_READ_INDEX    = 8'h05;
   localparam logic [7:0] ADDR_LOST_COUNT    = 8'h06;
   localparam logic [7:0] ADDR_FILL_COUNT    = 8'h07;
   localparam logic [7:0] ADDR_READ_PORT     = 8'h08;
   localparam logic [7:0] ADDR_AFULL_THRESH  = 8'h09;
   localparam logic [7:0] ADDR_BEHAVIOUR     = 8'h0A;
   localparam logic [7:0] ADDR_SYSTEM_CTRL   = 8'h0D;

   // Field positions in the behaviour control register.
   localparam int BIT_FLUSH_REQUEST   = 4;
   localparam int BIT_READ_CLEARS     = 3;
   localparam int BIT_AFULL_REPEAT    = 2;
   localparam int BIT_ROLL_OVER       = 1;

   // Field positions in the system control register.
   localparam int BIT_ONE_CHANNEL     = 3;
   localparam int BIT_DYN_POWER_DOWN  = 2;
   localparam int BIT_POWER_SAVE      = 1;
   localparam int BIT_SOFT_RESET      = 0;

   // Sample store geometry.
   localparam int         STORE_DEPTH   = 128;
   localparam int         INDEX_W       = 7;
   localparam logic [7:0] STORE_FULL    = 8'h80;
   localparam logic [6:0] LOST_MAX      = 7'h7F;

   // Values after reset.
   localparam logic [6:0] RST_AFULL_THRESH = 7'h3F;
   localparam logic [6:0] RST_INDEX        = 7'h00;
   localparam logic [7:0] RST_FILL         = 8'h00;
   localparam logic [6:0] RST_LOST         = 7'h00;
   localparam logic [7:0] RST_DATA         = 8'h00;

   // Ingress buffer geometry.
   localparam int SAMPLE_W      = 8;
   localparam int INGRESS_DEPTH = 16;

endpackage : sample_fifo_pkg

`default_nettype wire
